// ---- shared/cfio_defines.vh ----
// Constants shared by the configurable pad cell ring and its startup sequencer.
// Assumes inclusion by bare name from design files; definitions only.
`ifndef CFIO_DEFINES_VH
`define CFIO_DEFINES_VH

// ----------------------------------------------------------------------
// Die geometry
// ----------------------------------------------------------------------
`define CFIO_NUM_EDGES 4
`define CFIO_LINES_PER_EDGE 2
`define CFIO_CELLS_PER_EDGE 8

// ----------------------------------------------------------------------
// Output buffer tristate modes
// ----------------------------------------------------------------------
`define CFIO_TS_ON 2'h0
`define CFIO_TS_OFF 2'h1
`define CFIO_TS_PIN 2'h2

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CFIO_CLK_NS 20
`define CFIO_SETTLE_NS 1000
`define CFIO_SETTLE_CYC ((`CFIO_SETTLE_NS + `CFIO_CLK_NS - 1) / `CFIO_CLK_NS)
`define CFIO_CNT_W 12

// ----------------------------------------------------------------------
// Startup states, one-hot
// ----------------------------------------------------------------------
`define CFIO_ST_CONFIG 3'h1
`define CFIO_ST_SETTLE 3'h2
`define CFIO_ST_USER 3'h4

`endif

// ---- core/cfio_startup.v ----
// Startup sequencer: tracks configuration and opens the soft startup window.
// Assumes i_cfg_busy is synchronous to i_clk and high while configuring.
`timescale 1ns/1ns
`include "cfio_defines.vh"

module cfio_startup #(
   parameter SETTLE_CYC = `CFIO_SETTLE_CYC
) (
   // Clock, reset, enable
   input wire i_clk,
   input wire i_rstn,
   input wire i_ce,
   // Configuration status
   input wire i_cfg_busy,
   // Sequencer outputs
   output reg o_user_mode,
   output reg o_start,
   output reg o_soft_window
);

   // ----------------------------------------------------------------------
   // State machine
   // ----------------------------------------------------------------------
   localparam [2:0] ST_CONFIG = `CFIO_ST_CONFIG;
   localparam [2:0] ST_SETTLE = `CFIO_ST_SETTLE;
   localparam [2:0] ST_USER = `CFIO_ST_USER;
   localparam integer SETTLE_LAST = SETTLE_CYC - 1;

   reg [2:0] state_q;
   reg [2:0] state_d;
   reg [`CFIO_CNT_W-1:0] cnt_q;

   always @* begin
      state_d = state_q;
      case (state_q)
         ST_CONFIG: begin
            if (!i_cfg_busy) state_d = ST_SETTLE;
         end
         ST_SETTLE: begin
            if (i_cfg_busy) state_d = ST_CONFIG;
            else if (cnt_q == SETTLE_LAST[`CFIO_CNT_W-1:0]) state_d = ST_USER;
         end
         ST_USER: begin
            if (i_cfg_busy) state_d = ST_CONFIG;
         end
         default: begin
            state_d = ST_CONFIG;
         end
      endcase
   end

   // Settle window counts from entry into user mode, during which the first
   // activation of every output stays slew limited.
   always @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         state_q <= ST_CONFIG;
         cnt_q <= {`CFIO_CNT_W{1'b0}};
         o_user_mode <= 1'b0;
         o_start <= 1'b0;
         o_soft_window <= 1'b0;
      end else if (i_ce) begin
         state_q <= state_d;
         if (state_q == ST_SETTLE)
            cnt_q <= cnt_q + 1'b1;
         else
            cnt_q <= {`CFIO_CNT_W{1'b0}};
         o_user_mode <= (state_d != ST_CONFIG);
         o_start <= (state_q == ST_CONFIG) && (state_d == ST_SETTLE);
         o_soft_window <= (state_d == ST_SETTLE);
      end
   end

endmodule

// ---- core/cfio_pad_ring.v ----
// Ring of configurable pad cells between package pins and the logic tiles.
// Assumes pins, clock lines and configuration bits are synchronous to i_clk;
// the pin wire level is resolved outside from o_pad_out and o_pad_oe.
//
// How it works
// - Input storage selectable as flip-flop or latch
// - Two clock lines per edge, polarity per line
// - Rising setting makes latches transparent while low
// - Storage cleared during configuration and chip reset
// - Direct and stored inputs offered together
// - Tristate one disables buffer, zero drives
// - Buffer forced on, forced off, or pin controlled
// - One bit inverts tristate sense per cell
// - One bit inverts output data per cell
// - Output direct or rising-edge registered
// - Output register clock from either edge line
// - Per output fast or slew limited transitions
// - First activation after configuration slew limited
// - Weak pull-up default on, inputs only
`timescale 1ns/1ns
`include "cfio_defines.vh"

module cfio_pad_ring #(
   parameter NUM_EDGES = `CFIO_NUM_EDGES,
   parameter LINES_PER_EDGE = `CFIO_LINES_PER_EDGE,
   parameter CELLS_PER_EDGE = `CFIO_CELLS_PER_EDGE,
   parameter SETTLE_CYC = `CFIO_SETTLE_CYC
) (
   // Clock, reset, enable
   input wire i_clk,
   input wire i_rstn,
   input wire i_ce,
   // Configuration status
   input wire i_cfg_busy,
   // Edge clock lines and their polarity bits
   input wire [NUM_EDGES*LINES_PER_EDGE-1:0] i_clk_line,
   input wire [NUM_EDGES*LINES_PER_EDGE-1:0] i_clk_line_inv,
   // Per cell configuration
   input wire [NUM_EDGES*CELLS_PER_EDGE-1:0] i_in_latch,
   input wire [NUM_EDGES*CELLS_PER_EDGE-1:0] i_in_clk_sel,
   input wire [NUM_EDGES*CELLS_PER_EDGE-1:0] i_out_reg,
   input wire [NUM_EDGES*CELLS_PER_EDGE-1:0] i_out_clk_sel,
   input wire [NUM_EDGES*CELLS_PER_EDGE-1:0] i_out_inv,
   input wire [2*NUM_EDGES*CELLS_PER_EDGE-1:0] i_ts_mode,
   input wire [NUM_EDGES*CELLS_PER_EDGE-1:0] i_ts_inv,
   input wire [NUM_EDGES*CELLS_PER_EDGE-1:0] i_fast,
   input wire [NUM_EDGES*CELLS_PER_EDGE-1:0] i_pullup,
   // Logic tile side
   input wire [NUM_EDGES*CELLS_PER_EDGE-1:0] i_dout,
   input wire [NUM_EDGES*CELLS_PER_EDGE-1:0] i_tctl,
   output wire [NUM_EDGES*CELLS_PER_EDGE-1:0] o_in_direct,
   output wire [NUM_EDGES*CELLS_PER_EDGE-1:0] o_in_stored,
   // Pin side
   input wire [NUM_EDGES*CELLS_PER_EDGE-1:0] i_pad_in,
   output wire [NUM_EDGES*CELLS_PER_EDGE-1:0] o_pad_out,
   output wire [NUM_EDGES*CELLS_PER_EDGE-1:0] o_pad_oe,
   output wire [NUM_EDGES*CELLS_PER_EDGE-1:0] o_fast_slew,
   output wire [NUM_EDGES*CELLS_PER_EDGE-1:0] o_pullup_en,
   // Status
   output wire o_user_mode
);

   localparam NUM_LINES = NUM_EDGES * LINES_PER_EDGE;
   localparam NUM_CELLS = NUM_EDGES * CELLS_PER_EDGE;

   // ----------------------------------------------------------------------
   // Startup sequencing
   // ----------------------------------------------------------------------
   wire user_mode;
   wire start_pulse;
   wire soft_window;

   cfio_startup #(
      .SETTLE_CYC(SETTLE_CYC)
   ) u_startup (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .i_ce(i_ce),
      .i_cfg_busy(i_cfg_busy),
      .o_user_mode(user_mode),
      .o_start(start_pulse),
      .o_soft_window(soft_window)
   );

   assign o_user_mode = user_mode;

   // ----------------------------------------------------------------------
   // Edge clock lines
   // ----------------------------------------------------------------------
   // Polarity belongs to the line, so every cell on a line sees one sense.
   // Lines are sampled levels: each level must stand for a full i_clk period.
   wire [NUM_LINES-1:0] line_eff;
   wire [NUM_LINES-1:0] line_rise;

   genvar l;
   generate
      for (l = 0; l < NUM_LINES; l = l + 1) begin : g_line
         reg prev_q;
         reg seen_q;
         assign line_eff[l] = i_clk_line[l] ^ i_clk_line_inv[l];
         // No edge counts until one sample after reset, so a line that is
         // already high when reset lifts does not clock the storage
         assign line_rise[l] = line_eff[l] & ~prev_q & seen_q;
         always @(posedge i_clk or negedge i_rstn) begin
            if (!i_rstn) begin
               prev_q <= 1'b0;
               seen_q <= 1'b0;
            end else if (i_ce) begin
               prev_q <= line_eff[l];
               seen_q <= 1'b1;
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------------
   // Pad cells
   // ----------------------------------------------------------------------
   genvar k;
   generate
      for (k = 0; k < NUM_CELLS; k = k + 1) begin : g_cell
         localparam EDGE = k / CELLS_PER_EDGE;

         reg in_q;
         reg oreg_q;
         reg dir_q;
         reg dout_q;
         reg oe_q;
         reg fast_q;
         reg pu_q;
         reg soft_q;
         reg t_eff;

         wire in_line;
         wire in_rise;
         wire out_rise;
         wire data_src;
         wire data_val;
         wire drive_ok;

         // Each cell picks one of the lines that run along its own edge
         assign in_line = line_eff[EDGE*LINES_PER_EDGE + i_in_clk_sel[k]];
         assign in_rise = line_rise[EDGE*LINES_PER_EDGE + i_in_clk_sel[k]];
         assign out_rise = line_rise[EDGE*LINES_PER_EDGE + i_out_clk_sel[k]];

         // ----------------------------------------------------------------
         // Output data and buffer control
         // ----------------------------------------------------------------
         assign data_src = i_out_reg[k] ? oreg_q : i_dout[k];
         assign data_val = data_src ^ i_out_inv[k];

         // A logic one on the effective control turns the buffer off
         always @* begin
            t_eff = 1'b1;
            case (i_ts_mode[2*k+1:2*k])
               `CFIO_TS_ON: t_eff = 1'b0;
               `CFIO_TS_OFF: t_eff = 1'b1;
               `CFIO_TS_PIN: t_eff = i_tctl[k] ^ i_ts_inv[k];
               default: t_eff = 1'b1;
            endcase
         end

         // ----------------------------------------------------------------
         // Storage elements
         // ----------------------------------------------------------------
         always @(posedge i_clk or negedge i_rstn) begin
            if (!i_rstn) begin
               in_q <= 1'b0;
               oreg_q <= 1'b0;
            end else if (i_ce) begin
               if (i_cfg_busy) begin
                  in_q <= 1'b0;
                  oreg_q <= 1'b0;
               end else begin
                  // Latch is open while the effective line is low
                  if (i_in_latch[k]) begin
                     if (!in_line) in_q <= i_pad_in[k];
                  end else if (in_rise) begin
                     in_q <= i_pad_in[k];
                  end
                  if (out_rise) oreg_q <= i_dout[k];
               end
            end
         end

         // Busy must drop the drive in its first cycle, while user mode is
         // still high, or the buffer and fast slew would linger one clock.
         assign drive_ok = user_mode & ~i_cfg_busy;

         // ----------------------------------------------------------------
         // Pin drive, slew and pull-up; outputs stay off until user mode
         // ----------------------------------------------------------------
         always @(posedge i_clk or negedge i_rstn) begin
            if (!i_rstn) begin
               dir_q <= 1'b0;
               dout_q <= 1'b0;
               oe_q <= 1'b0;
               fast_q <= 1'b0;
               pu_q <= 1'b1;
               soft_q <= 1'b1;
            end else if (i_ce) begin
               dir_q <= i_pad_in[k];
               dout_q <= data_val;
               // Forced-on mode too waits for user mode
               oe_q <= drive_ok & ~t_eff;
               // Soft flag holds until the window closes with the buffer on
               if (i_cfg_busy || start_pulse)
                  soft_q <= 1'b1;
               else if (oe_q && !soft_window)
                  soft_q <= 1'b0;
               fast_q <= drive_ok & i_fast[k] & ~soft_q & ~soft_window;
               // Pull-up may only act while the buffer is off
               if (!drive_ok)
                  pu_q <= 1'b1;
               else
                  pu_q <= i_pullup[k] & t_eff;
            end
         end

         assign o_in_direct[k] = dir_q;
         assign o_in_stored[k] = in_q;
         assign o_pad_out[k] = dout_q;
         assign o_pad_oe[k] = oe_q;
         assign o_fast_slew[k] = fast_q;
         assign o_pullup_en[k] = pu_q;
      end
   endgenerate

endmodule

// ---- sim/cfio_ring_props.sv ----
// Port-level checker for the pad cell ring; cell 0 stands for the storage paths.
// Assumes it is bound to cfio_pad_ring and sees nothing but its ports.
`timescale 1ns/1ns
module cfio_ring_props #(
   parameter NUM_EDGES = 4,
   parameter LINES_PER_EDGE = 2,
   parameter CELLS_PER_EDGE = 8,
   parameter N = NUM_EDGES*CELLS_PER_EDGE,
   parameter L = NUM_EDGES*LINES_PER_EDGE
) (
   input wire i_clk,
   input wire i_rstn,
   input wire i_ce,
   input wire i_cfg_busy,
   input wire [L-1:0] i_clk_line,
   input wire [L-1:0] i_clk_line_inv,
   input wire [N-1:0] i_in_latch,
   input wire [N-1:0] i_in_clk_sel,
   input wire [2*N-1:0] i_ts_mode,
   input wire [N-1:0] i_ts_inv,
   input wire [N-1:0] i_tctl,
   input wire [N-1:0] i_pad_in,
   input wire [N-1:0] o_in_direct,
   input wire [N-1:0] o_in_stored,
   input wire [N-1:0] o_pad_oe,
   input wire [N-1:0] o_fast_slew,
   input wire [N-1:0] o_pullup_en,
   input wire o_user_mode
);
   wire go = i_ce && !i_cfg_busy;
   wire ein = i_clk_line[i_in_clk_sel[0]] ^ i_clk_line_inv[i_in_clk_sel[0]];
   reg [N-1:0] oe_v;
   integer k;
   always @* begin
      for (k = 0; k < N; k = k + 1) begin
         oe_v[k] = i_ts_mode[2*k+:2] == 2'h0 ||
            (i_ts_mode[2*k+:2] == 2'h2 && !(i_tctl[k] ^ i_ts_inv[k]));
      end
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);
   sequence s_in_rise;
      !ein && go ##1 ein && go && !i_in_latch[0];
   endsequence
   AST_CFG_CLEAR: assert property (i_ce && i_cfg_busy |=>
      !o_user_mode && o_pad_oe == 0 && o_in_stored == 0 && &o_pullup_en) else $error("clear");
   AST_USER_ON: assert property (go |=> o_user_mode) else $error("user mode");
   AST_SLOW_CFG: assert property (!o_user_mode |-> o_fast_slew == 0) else $error("slew");
   AST_PULL_IN: assert property ((o_pullup_en & o_pad_oe) == 0) else $error("pull");
   AST_OE: assert property (go && o_user_mode |=> o_pad_oe == $past(oe_v))
      else $error("oe");
   AST_DIRECT: assert property (go |=> o_in_direct == $past(i_pad_in)) else $error("direct");
   AST_LATCH: assert property (go && i_in_latch[0] && !ein |=>
      o_in_stored[0] == $past(i_pad_in[0])) else $error("latch");
   AST_FF: assert property (s_in_rise |=> o_in_stored[0] == $past(i_pad_in[0]))
      else $error("flop");
endmodule
bind cfio_pad_ring cfio_ring_props #(.NUM_EDGES(NUM_EDGES), .LINES_PER_EDGE(LINES_PER_EDGE),
   .CELLS_PER_EDGE(CELLS_PER_EDGE)) u_props (.*);

// ---- sim/cfio_pin_model.sv ----
// Board side of every pad: cell driver, board driver, pull-up.
// Assumes no contention is commanded; an undriven pin without pull-up toggles.
`timescale 1ns/1ns
module cfio_pin_model #(
   parameter N = 32
) (
   input wire i_clk,
   input wire [N-1:0] i_out,
   input wire [N-1:0] i_oe,
   input wire [N-1:0] i_pull,
   input wire [N-1:0] i_ext_en,
   input wire [N-1:0] i_ext_val,
   output wire [N-1:0] o_pin
);
   reg float_q = 1'b0;
   // A floating pin wanders so a stale level never passes as a driven one
   always @(posedge i_clk) float_q <= ~float_q;
   assign o_pin = (i_oe & i_out) | (~i_oe & i_ext_en & i_ext_val)
      | (~i_oe & ~i_ext_en & (i_pull | {N{float_q}}));
endmodule

// ---- sim/cfio_pad_ring_tb.sv ----
// Self-checking bench for the pad cell ring; inputs change at the falling edge.
// Assumes the pin model resolves the pads and the checker is bound to the ring.
`timescale 1ns/1ns
module cfio_pad_ring_tb;
   localparam N = 32;
   reg i_clk = 1'b0;
   reg i_rstn, i_ce, i_cfg_busy;
   reg [7:0] i_clk_line, i_clk_line_inv;
   reg [N-1:0] i_in_latch, i_in_clk_sel, i_out_reg, i_out_clk_sel, i_out_inv, i_ts_inv;
   reg [N-1:0] i_fast, i_pullup, i_dout, i_tctl, ext_en, ext_val, a, b;
   reg [2*N-1:0] i_ts_mode;
   wire [N-1:0] i_pad_in, o_in_direct, o_in_stored, o_pad_out, o_pad_oe, o_fast_slew;
   wire [N-1:0] o_pullup_en;
   wire o_user_mode;
   integer n_fail = 0, comparisons = 0, m, t, v;
   initial begin
      forever #10 i_clk = ~i_clk;
   end
   cfio_pad_ring #(.SETTLE_CYC(4)) dut (.*);
   cfio_pin_model #(.N(N)) u_pin (.i_clk(i_clk), .i_out(o_pad_out), .i_oe(o_pad_oe),
      .i_pull(o_pullup_en), .i_ext_en(ext_en), .i_ext_val(ext_val), .o_pin(i_pad_in));
   task chk(input [8*8-1:0] what, input [N-1:0] exp, input [N-1:0] got);
      begin
         comparisons = comparisons + 1;
         if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("[ERR] %0s exp %h got %h", what, exp, got);
         end
      end
   endtask
   task tick(input integer n);
      repeat (n) @(negedge i_clk);
   endtask
   task give_verdict;
      begin
         $display("comparisons %0d n_fail %0d", comparisons, n_fail);
         if (n_fail == 0 && comparisons > 0) begin
            $display("TB: PASS");
         end else begin
            $display("TB: FAIL");
         end
         $finish;
      end
   endtask
   initial begin
      {i_rstn, i_cfg_busy, i_clk_line, i_clk_line_inv, i_in_latch, i_in_clk_sel} = '0;
      {i_out_reg, i_out_clk_sel, i_out_inv, i_ts_inv, i_dout, i_tctl, i_ts_mode} = '0;
      {ext_en, ext_val} = '0;
      {i_ce, i_fast, i_pullup} = '1;
      tick(4);
      chk("rst_oe", 32'h0, o_pad_oe);
      chk("rst_pull", {N{1'b1}}, o_pullup_en);
      i_rstn = 1'b1;
      i_cfg_busy = 1'b1;
      tick(2);
      chk("cfg_usr", 32'h0, {31'h0, o_user_mode});
      i_cfg_busy = 1'b0;
      i_dout = 32'h0000_a5a5;
      tick(2);
      chk("oe_on", {N{1'b1}}, o_pad_oe);
      chk("soft", 32'h0, o_fast_slew);
      v = 0;
      while (o_fast_slew !== {N{1'b1}} && v < 40) begin
         tick(1);
         v = v + 1;
      end
      chk("fast", {N{1'b1}}, o_fast_slew);
      i_out_inv = 32'h5555_5555;
      i_fast = 32'h0000_ffff;
      for (m = 0; m < 4; m = m + 1) begin
         for (t = 0; t < 4; t = t + 1) begin
            i_ts_mode = {N{m[1:0]}};
            {i_ts_inv, i_tctl} = {{N{t[1]}}, {N{t[0]}}};
            tick(2);
            v = (m == 0) || (m == 2 && t[0] == t[1]);
            chk("oe", {N{v[0]}}, o_pad_oe);
            chk("pull", {N{~v[0]}}, o_pullup_en);
            chk("dout", i_dout ^ i_out_inv, o_pad_out);
            chk("slew", i_fast, o_fast_slew);
         end
      end
      {i_ts_mode, i_ts_inv, i_out_inv} = {{N{2'h2}}, 64'h0};
      for (v = 0; v < 2; v = v + 1) begin
         {i_dout, i_tctl} = {2*N{v[0]}};
         tick(3);
         chk("odrain", {N{v[0]}}, o_in_direct);
      end
      {i_ts_mode, ext_en} = {{N{2'h1}}, {N{1'b1}}};
      a = 32'h1234_abcd;
      b = 32'hfedc_0987;
      ext_val = a;
      tick(2);
      chk("no_rise", 32'h0, o_in_stored);
      i_clk_line = 8'hff;
      tick(2);
      chk("ff_cap", a, o_in_stored);
      {i_in_clk_sel, ext_val, i_clk_line_inv} = {32'hff00_ff00, b, 8'haa};
      tick(2);
      i_clk_line_inv = 8'h00;
      tick(2);
      a = (b & i_in_clk_sel) | (a & ~i_in_clk_sel);
      chk("line_pol", a, o_in_stored);
      {i_in_latch, ext_val} = {{N{1'b1}}, ~b};
      tick(2);
      chk("lat_hold", a, o_in_stored);
      i_clk_line = 8'h00;
      tick(2);
      chk("lat_open", ~b, o_in_stored);
      chk("direct", ~b, o_in_direct);
      {i_clk_line_inv, ext_val} = {8'hff, b};
      tick(2);
      chk("lat_inv", ~b, o_in_stored);
      i_cfg_busy = 1'b1;
      tick(2);
      chk("clear", 32'h0, o_in_stored);
      {i_cfg_busy, ext_en, i_ts_mode, i_clk_line_inv, i_out_reg} = {1'b0, 104'h0, {N{1'b1}}};
      {i_out_clk_sel, i_dout} = {32'h00ff_00ff, a};
      tick(3);
      i_clk_line = 8'h55;
      tick(3);
      chk("oreg0", a & ~i_out_clk_sel, o_pad_out);
      {i_dout, i_clk_line} = {b, 8'hff};
      tick(3);
      a = (b & i_out_clk_sel) | (a & ~i_out_clk_sel);
      chk("oreg1", a, o_pad_out);
      // Enable low: new data and a forced-off mode must not reach the pins
      {i_ce, i_dout, i_ts_mode, i_clk_line} = {1'b0, ~b, {N{2'h1}}, 8'h00};
      tick(3);
      chk("ce_oe", {N{1'b1}}, o_pad_oe);
      chk("ce_out", a, o_pad_out);
      // Mid-run reset with every line already high: no capture on release
      {i_rstn, i_ce, i_in_latch, i_clk_line} = {2'b01, 32'h0, 8'hff};
      {ext_en, ext_val} = {{N{1'b1}}, b};
      tick(2);
      chk("rst_st", 32'h0, o_in_stored | o_pad_oe | o_fast_slew);
      chk("rst_pu", {N{1'b1}}, o_pullup_en);
      i_rstn = 1'b1;
      tick(2);
      chk("rst_rise", 32'h0, o_in_stored);
      chk("rst_usr", 32'h1, {31'h0, o_user_mode});
      give_verdict;
   end
endmodule
